// *** common/rec_mode_defines.vh ***
`ifndef REC_MODE_DEFINES_VH
`define REC_MODE_DEFINES_VH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_REC_CTRL   8'h1a
`define ADDR_DECIM      8'h32
`define ADDR_UPD_INT    8'h5e
`define ADDR_INT_SCL    8'h60
`define ADDR_GLOB_CMD   8'h3e
`define ADDR_STATUS     8'h40
`define ADDR_X_BUF      8'h06
`define ADDR_Y_BUF      8'h08

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_REC_CTRL    16'h1102
`define RST_DECIM       16'h9630
`define RST_UPD_INT     16'h0fa0
`define RST_INT_SCL     2'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define MODE_LSB        0
`define STORE_LSB       2
`define PDOWN_BIT       7
`define SR_EN_LSB       8
`define WIN_LSB         12
`define HALT_BIT        11

// ----------------------------------------
// encodings
// ----------------------------------------
`define MODE_MAN_FFT    2'h0
`define MODE_AUTO_FFT   2'h1
`define MODE_TIME       2'h2
`define MODE_RT         2'h3
`define STORE_ALARM     2'h1
`define STORE_ALL       2'h2
`define SCL_US          2'h0
`define SCL_MS          2'h1
`define SCL_128         2'h2
`define DEC_MAX         4'ha

// ----------------------------------------
// counts and times
// ----------------------------------------
`define CAPT_SAMPLES    512
`define RT_PRE_DIV      2'h3
`define CLK_PERIOD_NS   10
`define STEP0_NS        30520
`define STEP1_NS        488000
`define STEP2_NS        7812500
`define STEP3_NS        1000000000

`endif

// *** logic/skid_buf2.v ***
`timescale 1ns/1ps

module skid_buf2 #(
  parameter W = 32
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  input  wire         flush,
  // fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg         v0_r;
  reg         v1_r;
  reg [W-1:0] d0_r;
  reg [W-1:0] d1_r;
  wire        push;
  wire        pop;

  assign push      = in_valid & ~v1_r;
  assign pop       = v0_r & out_ready;
  assign in_ready  = ~v1_r;
  assign out_valid = v0_r;
  assign out_data  = d0_r;

  always @(posedge clk) begin
    if (rst | flush) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!v0_r) begin
            d0_r <= in_data;
            v0_r <= 1'b1;
          end else begin
            d1_r <= in_data;
            v1_r <= 1'b1;
          end
        end
        2'b01: begin
          d0_r <= d1_r;
          v0_r <= v1_r;
          v1_r <= 1'b0;
        end
        2'b11: begin
          if (v1_r) begin
            d0_r <= d1_r;
            d1_r <= in_data;
          end else begin
            d0_r <= in_data;
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule // skid_buf2

// *** logic/rec_mode_ctrl.v ***
`timescale 1ns/1ps
`include "rec_mode_defines.vh"

module rec_mode_ctrl #(
  parameter        NSMP      = `CAPT_SAMPLES,
  parameter [31:0] STEP0_CYC = `STEP0_NS / `CLK_PERIOD_NS,
  parameter [31:0] STEP1_CYC = `STEP1_NS / `CLK_PERIOD_NS,
  parameter [31:0] STEP2_CYC = `STEP2_NS / `CLK_PERIOD_NS,
  parameter [31:0] STEP3_CYC = `STEP3_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire        CLK,
  input  wire        RST,
  // register port
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [7:0]  REG_ADDR,
  input  wire [15:0] REG_WDATA,
  output wire [15:0] REG_RDATA,
  // gateway events
  input  wire        CFG_PKT,
  input  wire        START,
  input  wire        ALARM,
  // sample stream, both axes
  input  wire        SMP_VALID,
  input  wire [15:0] SMP_X,
  input  wire [15:0] SMP_Y,
  // captured words out
  output wire        OUT_VALID,
  input  wire        OUT_READY,
  output wire [31:0] OUT_DATA,
  output wire        OUT_WIN_EN,
  output wire [1:0]  OUT_WIN,
  output wire [1:0]  OUT_RATE_OPT,
  // spectral engine
  output wire        PROC_REQ,
  input  wire        PROC_DONE,
  // radio hand-off
  output wire        SEND_REQ,
  input  wire        SEND_DONE,
  // node status
  output wire        STORE_REC,
  output wire        PWR_DOWN,
  output wire        RT_ACTIVE,
  output wire [15:0] RT_DATA
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_CAPT = 5'h02;
  localparam [4:0] ST_PROC = 5'h04;
  localparam [4:0] ST_SEND = 5'h08;
  localparam [4:0] ST_RT   = 5'h10;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [9:0] dec_mask;
    input [3:0] e;
    reg   [3:0] c;
    begin
      c = (e > `DEC_MAX) ? `DEC_MAX : e;
      dec_mask = (10'h001 << c) - 10'h001;
    end
  endfunction

  function [1:0] next_sr;
    input [3:0] en;
    input [1:0] from;
    reg   [1:0] k;
    reg         hit;
    integer     i;
    begin
      next_sr = from;
      hit = 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        k = from + i[1:0];
        if (!hit && en[k]) begin
          next_sr = k;
          hit = 1'b1;
        end
      end
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [15:0] rec_ctrl_r;
  reg [15:0] decim_r;
  reg [15:0] upd_int_r;
  reg [1:0]  int_scl_r;
  reg [15:0] rdata_r;
  reg [4:0]  state_r;
  reg [4:0]  state_nxt;
  reg        armed_r;
  reg [1:0]  sr_ptr_r;
  reg [1:0]  sr_cur_r;
  reg [9:0]  dec_cnt_r;
  reg [9:0]  smp_cnt_r;
  reg [1:0]  rt_pre_r;
  reg        axis_y_r;
  reg [15:0] rt_data_r;
  reg        proc_req_r;
  reg        send_req_r;
  reg        store_r;
  reg        pdown_r;
  reg        win_en_r;
  reg [31:0] step_cnt_r;
  reg [15:0] int_cnt_r;
  reg        wake_r;

  wire [1:0] mode     = rec_ctrl_r[`MODE_LSB +: 2];
  wire [1:0] store_md = rec_ctrl_r[`STORE_LSB +: 2];
  wire [3:0] sr_en    = rec_ctrl_r[`SR_EN_LSB +: 4];
  wire [1:0] win      = rec_ctrl_r[`WIN_LSB +: 2];
  wire       pd_en    = rec_ctrl_r[`PDOWN_BIT];
  wire       halt     = REG_WR && (REG_ADDR == `ADDR_GLOB_CMD) && REG_WDATA[`HALT_BIT];
  wire       auto_md  = (mode == `MODE_AUTO_FFT);
  wire       trig_cmd = START | CFG_PKT;
  wire       trig     = trig_cmd | (auto_md & armed_r & wake_r);
  wire [1:0] sr_sel   = next_sr(sr_en, sr_ptr_r);
  wire [3:0] dec_cur  = decim_r[{sr_cur_r, 2'h0} +: 4];
  wire       take     = SMP_VALID && (dec_cnt_r == dec_mask(dec_cur));
  wire       buf_rdy;
  wire       push     = (state_r == ST_CAPT) && take && buf_rdy;
  wire       last     = (smp_cnt_r == NSMP[9:0] - 10'h001);
  wire       rt_take  = SMP_VALID && (rt_pre_r == `RT_PRE_DIV)
                        && (dec_cnt_r == dec_mask(decim_r[3:0]));
  wire       rec_end  = (state_r == ST_SEND) && SEND_DONE;

  // ----------------------------------------
  // register writes and reads
  // ----------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      rec_ctrl_r <= `RST_REC_CTRL;
      decim_r    <= `RST_DECIM;
      upd_int_r  <= `RST_UPD_INT;
      int_scl_r  <= `RST_INT_SCL;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `ADDR_REC_CTRL: rec_ctrl_r <= REG_WDATA;
        `ADDR_DECIM:    decim_r    <= REG_WDATA;
        `ADDR_UPD_INT:  upd_int_r  <= REG_WDATA;
        `ADDR_INT_SCL:  int_scl_r  <= REG_WDATA[1:0];
        default: begin
        end
      endcase
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      rdata_r  <= 16'h0000;
      axis_y_r <= 1'b0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `ADDR_REC_CTRL: rdata_r <= rec_ctrl_r;
        `ADDR_DECIM:    rdata_r <= decim_r;
        `ADDR_UPD_INT:  rdata_r <= upd_int_r;
        `ADDR_INT_SCL:  rdata_r <= {14'h0000, int_scl_r};
        `ADDR_STATUS:   rdata_r <= {7'h00, pdown_r, armed_r, sr_cur_r, state_r};
        `ADDR_X_BUF: begin
          rdata_r  <= rt_data_r;
          axis_y_r <= 1'b0;
        end
        `ADDR_Y_BUF: begin
          rdata_r  <= rt_data_r;
          axis_y_r <= 1'b1;
        end
        default: rdata_r <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // wake-up timer
  // ----------------------------------------
  reg [31:0] step_lim;
  always @* begin
    case (int_scl_r)
      `SCL_US:  step_lim = STEP0_CYC;
      `SCL_MS:  step_lim = STEP1_CYC;
      `SCL_128: step_lim = STEP2_CYC;
      default:  step_lim = STEP3_CYC;
    endcase
  end

  always @(posedge CLK) begin
    if (RST || halt || !(auto_md && armed_r) || state_r != ST_IDLE) begin
      step_cnt_r <= 32'h0000_0000;
      int_cnt_r  <= 16'h0000;
      wake_r     <= 1'b0;
    end else begin
      wake_r <= 1'b0;
      if (step_cnt_r >= step_lim - 32'h1) begin
        step_cnt_r <= 32'h0000_0000;
        if (int_cnt_r >= upd_int_r - 16'h1) begin
          int_cnt_r <= 16'h0000;
          wake_r    <= 1'b1;
        end else begin
          int_cnt_r <= int_cnt_r + 16'h1;
        end
      end else begin
        step_cnt_r <= step_cnt_r + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (!halt && trig) begin
          if (mode == `MODE_RT)
            state_nxt = ST_RT;
          else if (sr_en != 4'h0)
            state_nxt = ST_CAPT;
        end
      end
      ST_CAPT: begin
        if (push && last)
          state_nxt = (mode == `MODE_TIME) ? ST_SEND : ST_PROC;
      end
      ST_PROC: begin
        if (PROC_DONE)
          state_nxt = ST_SEND;
      end
      ST_SEND: begin
        if (SEND_DONE)
          state_nxt = ST_IDLE;
      end
      ST_RT: state_nxt = ST_RT;
      default: state_nxt = ST_IDLE;
    endcase
    if (halt)
      state_nxt = ST_IDLE;
  end

  always @(posedge CLK) begin
    if (RST) begin
      state_r    <= ST_IDLE;
      armed_r    <= 1'b0;
      sr_ptr_r   <= 2'h0;
      sr_cur_r   <= 2'h0;
      proc_req_r <= 1'b0;
      send_req_r <= 1'b0;
      store_r    <= 1'b0;
      pdown_r    <= 1'b0;
      win_en_r   <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      proc_req_r <= 1'b0;
      send_req_r <= 1'b0;
      store_r    <= 1'b0;
      if (halt) begin
        armed_r  <= 1'b0;
        sr_ptr_r <= 2'h0;
      end else if (trig_cmd) begin
        armed_r  <= 1'b1;
      end
      if (state_r == ST_IDLE && state_nxt == ST_CAPT) begin
        sr_cur_r <= sr_sel;
        win_en_r <= (mode != `MODE_TIME);
        pdown_r  <= 1'b0;
      end
      if (state_r == ST_CAPT && state_nxt == ST_PROC)
        proc_req_r <= 1'b1;
      if (state_r != ST_SEND && state_nxt == ST_SEND)
        send_req_r <= 1'b1;
      if (rec_end && !halt) begin
        sr_ptr_r <= sr_cur_r + 2'h1;
        pdown_r  <= pd_en;
        store_r  <= (store_md == `STORE_ALL)
                    || (store_md == `STORE_ALARM && ALARM);
      end
      if (REG_WR && REG_ADDR == `ADDR_REC_CTRL)
        sr_ptr_r <= 2'h0;
    end
  end

  // ----------------------------------------
  // sample decimation and capture count
  // ----------------------------------------
  always @(posedge CLK) begin
    if (RST || halt || state_r == ST_IDLE) begin
      dec_cnt_r <= 10'h000;
      smp_cnt_r <= 10'h000;
      rt_pre_r  <= 2'h0;
    end else if (state_r == ST_CAPT) begin
      if (take && buf_rdy) begin
        dec_cnt_r <= 10'h000;
        smp_cnt_r <= smp_cnt_r + 10'h001;
      end else if (SMP_VALID && !take) begin
        dec_cnt_r <= dec_cnt_r + 10'h001;
      end
    end else if (state_r == ST_RT && SMP_VALID) begin
      rt_pre_r <= rt_pre_r + 2'h1;
      if (rt_pre_r == `RT_PRE_DIV)
        dec_cnt_r <= rt_take ? 10'h000 : dec_cnt_r + 10'h001;
    end
  end

  // ----------------------------------------
  // real-time output register
  // ----------------------------------------
  always @(posedge CLK) begin
    if (RST)
      rt_data_r <= 16'h0000;
    else if (state_r == ST_RT && rt_take)
      rt_data_r <= axis_y_r ? SMP_Y : SMP_X;
  end

  // ----------------------------------------
  // output buffer
  // ----------------------------------------
  skid_buf2 #(
    .W         (32)
  ) u_buf (
    .clk       (CLK),
    .rst       (RST),
    .flush     (halt),
    .in_valid  ((state_r == ST_CAPT) && take),
    .in_ready  (buf_rdy),
    .in_data   ({SMP_Y, SMP_X}),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (OUT_DATA)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign REG_RDATA    = rdata_r;
  assign OUT_WIN_EN   = win_en_r;
  assign OUT_WIN      = rec_ctrl_r[`WIN_LSB +: 2];
  assign OUT_RATE_OPT = sr_cur_r;
  assign PROC_REQ     = proc_req_r;
  assign SEND_REQ     = send_req_r;
  assign STORE_REC    = store_r;
  assign PWR_DOWN     = pdown_r;
  assign RT_ACTIVE    = state_r[4];
  assign RT_DATA      = rt_data_r;

endmodule // rec_mode_ctrl

// *** testbench/far_side.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// far side: spectral engine and radio answer
// ----------------------------------------
module far_side (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // requests and answers
  input  wire logic PROC_REQ,
  input  wire logic SEND_REQ,
  output logic      PROC_DONE,
  output logic      SEND_DONE
);
  integer seed = 32'hb4e2;
  integer pc = 0;
  integer sc = 0;
  // delay of 1 to 8 cycles, prompt or slow
  always @(posedge CLK) begin
    PROC_DONE <= 1'b0;
    SEND_DONE <= 1'b0;
    if (RST) begin
      pc = 0;
      sc = 0;
    end else begin
      if (PROC_REQ) pc = 1 + ($random(seed) & 7);
      else if (pc > 0) begin
        pc = pc - 1;
        if (pc == 0) PROC_DONE <= 1'b1;
      end
      if (SEND_REQ) sc = 1 + ($random(seed) & 7);
      else if (sc > 0) begin
        sc = sc - 1;
        if (sc == 0) SEND_DONE <= 1'b1;
      end
    end
  end
endmodule // far_side

// *** testbench/rec_ctrl_props.sv ***
`timescale 1ns/1ps
module rec_ctrl_props (
  // clock and reset
  input wire        CLK,
  input wire        RST,
  // register port
  input wire        REG_WR,
  input wire        REG_RD,
  input wire [7:0]  REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire [15:0] REG_RDATA,
  // outputs watched
  input wire        OUT_VALID,
  input wire        OUT_READY,
  input wire        OUT_WIN_EN,
  input wire        PROC_REQ,
  input wire        SEND_REQ,
  input wire        PWR_DOWN,
  input wire        RT_ACTIVE,
  input wire [31:0] OUT_DATA,
  input wire [1:0]  OUT_WIN
);
  wire halt = REG_WR && REG_ADDR == 8'h3e && REG_WDATA[11];
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  property p_rst_val;
    disable iff (1'b0) RST |=> REG_RDATA == 16'h0000 && !PWR_DOWN && !RT_ACTIVE
      && OUT_WIN == 2'h1 && OUT_WIN_EN;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
  property p_rdata_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_proc_pulse; PROC_REQ |=> !PROC_REQ; endproperty
  a_proc_pulse: assert property (p_proc_pulse) else $error("compute request too long");
  property p_send_pulse; SEND_REQ |=> !SEND_REQ; endproperty
  a_send_pulse: assert property (p_send_pulse) else $error("send request too long");
  property p_rt_quiet; RT_ACTIVE |-> !PROC_REQ && !SEND_REQ; endproperty
  a_rt_quiet: assert property (p_rt_quiet) else $error("record activity in real time");
  property p_rt_stay; RT_ACTIVE && !halt |=> RT_ACTIVE; endproperty
  a_rt_stay: assert property (p_rt_stay) else $error("real time left without halt");
  property p_halt; halt |-> ##[1:2] (!RT_ACTIVE && !OUT_VALID); endproperty
  a_halt: assert property (p_halt) else $error("halt did not idle");
  property p_out_hold; OUT_VALID && !OUT_READY && !halt |=> OUT_VALID && $stable(OUT_DATA);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled word lost");
  c_proc: cover property (PROC_REQ);
  c_send: cover property (SEND_REQ);
  c_rt: cover property (RT_ACTIVE);
  c_stall: cover property (OUT_VALID && !OUT_READY);
endmodule // rec_ctrl_props

bind rec_mode_ctrl rec_ctrl_props rec_ctrl_props_i (.CLK(CLK), .RST(RST), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_WIN_EN(OUT_WIN_EN), .PROC_REQ(PROC_REQ),
  .SEND_REQ(SEND_REQ), .PWR_DOWN(PWR_DOWN), .RT_ACTIVE(RT_ACTIVE), .OUT_DATA(OUT_DATA),
  .OUT_WIN(OUT_WIN));

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic CLK = 0, RST = 1, REG_WR = 0, REG_RD = 0, CFG_PKT = 0, START = 0, ALARM = 0;
  logic SMP_VALID = 0, OUT_READY = 0, rd_d = 0, win_en = 1;
  logic [7:0]  REG_ADDR = 0;
  logic [15:0] REG_WDATA = 0, SMP_X = 0, SMP_Y = 0;
  logic [1:0]  ropt = 0;
  logic [31:0] e, rc = 0;
  logic [31:0] wq[$];
  logic [31:0] rq[$];
  logic [15:0] cfg[5] = '{16'h218a, 16'h0100, 16'h1304, 16'h1304, 16'h0101};
  wire  [15:0] REG_RDATA, RT_DATA;
  wire  [31:0] OUT_DATA;
  wire  [1:0]  OUT_WIN, OUT_RATE_OPT;
  wire OUT_VALID, OUT_WIN_EN, PROC_REQ, PROC_DONE, SEND_REQ, SEND_DONE, STORE_REC, PWR_DOWN;
  wire RT_ACTIVE;
  integer seed = 32'hb4e2, fail_count = 0, check_count = 0;
  integer n_proc = 0, n_send = 0, n_store = 0, n0, p0, s0, i, k, t;
  localparam int NS = 8;

  always #5 CLK = ~CLK;

  rec_mode_ctrl #(.NSMP(NS), .STEP0_CYC(4), .STEP1_CYC(5), .STEP2_CYC(6), .STEP3_CYC(7))
    rec_mode_ctrl_i (.CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CFG_PKT(CFG_PKT),
    .START(START), .ALARM(ALARM), .SMP_VALID(SMP_VALID), .SMP_X(SMP_X), .SMP_Y(SMP_Y),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_WIN_EN(OUT_WIN_EN),
    .OUT_WIN(OUT_WIN), .OUT_RATE_OPT(OUT_RATE_OPT), .PROC_REQ(PROC_REQ), .PROC_DONE(PROC_DONE),
    .SEND_REQ(SEND_REQ), .SEND_DONE(SEND_DONE), .STORE_REC(STORE_REC), .PWR_DOWN(PWR_DOWN),
    .RT_ACTIVE(RT_ACTIVE), .RT_DATA(RT_DATA));
  far_side far_side_i (.CLK(CLK), .RST(RST), .PROC_REQ(PROC_REQ), .SEND_REQ(SEND_REQ),
    .PROC_DONE(PROC_DONE), .SEND_DONE(SEND_DONE));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    REG_WR = 1; REG_ADDR = a; REG_WDATA = d;
    cyc(1);
    REG_WR = 0;
    cyc(1);
  endtask
  task rd(input logic [7:0] a, input logic [15:0] x, input logic [15:0] m);
    rq.push_back({m, x});
    REG_RD = 1; REG_ADDR = a;
    cyc(1);
    REG_RD = 0;
    cyc(1);
  endtask
  task smp(input logic [15:0] x, input logic [15:0] y, input logic keep);
    SMP_X = x; SMP_Y = y; SMP_VALID = 1;
    if (keep) wq.push_back({y, x});
    cyc(1);
    SMP_VALID = 0;
    cyc(3);
  endtask
  task trig(input logic by_cfg);
    if (by_cfg) CFG_PKT = 1; else START = 1;
    cyc(1);
    START = 0; CFG_PKT = 0;
  endtask
  task rec;
    n0 = n_send; p0 = n_proc; s0 = n_store;
    for (i = 0; i < NS; i++) smp($random(seed), $random(seed), 1);
    t = 0;
    while (n_send == n0 && t < 300) begin cyc(1); t++; end
    chk(n_send - n0, 1);
    cyc(12);
  endtask

  // ----------------------------------------
  // drain side: stalls, never 4 cycles long
  // ----------------------------------------
  always @(posedge CLK) begin
    rc = rc + 1;
    #1 OUT_READY = $random(seed) | (rc[1:0] == 2'h0);
  end

  // ----------------------------------------
  // monitor: reads, words, pulses
  // ----------------------------------------
  always @(posedge CLK) begin
    rd_d <= REG_RD;
    if (rd_d) begin
      e = rq.pop_front();
      chk(REG_RDATA & e[31:16], e[15:0]);
    end
    if (OUT_VALID && OUT_READY) begin
      chk(OUT_DATA, wq.size() ? wq.pop_front() : ~OUT_DATA);
      chk(OUT_WIN_EN, win_en);
      chk(OUT_RATE_OPT, ropt);
    end
    n_proc = n_proc + PROC_REQ;
    n_send = n_send + SEND_REQ;
    n_store = n_store + STORE_REC;
  end

  initial begin
    #100000;
    fail_count++;
    give_verdict;
  end

  initial begin
    cyc(10);
    RST = 0;
    rd(8'h1a, 16'h1102, 16'hffff);
    rd(8'h70, 16'h0000, 16'hffff);
    rd(8'h40, 16'h0001, 16'h001f);
    wr(8'h32, 16'h0000);
    wr(8'h5e, 16'h0003);
    wr(8'h60, 16'h0000);
    for (k = 0; k < 5; k++) begin
      if (k != 3) wr(8'h1a, cfg[k]);
      rd(8'h1a, cfg[k], 16'hffff);
      win_en = cfg[k][1:0] != 2'h2;
      ALARM = k == 2;
      ropt = k == 3;
      trig(k == 1);
      rec;
      chk(n_proc - p0, !cfg[k][1]);
      chk(n_store - s0, cfg[k][3:2] == 2'h2 || (cfg[k][3:2] == 2'h1 && ALARM));
      chk(PWR_DOWN, cfg[k][7]);
      chk(OUT_WIN, cfg[k][13:12]);
    end
    cyc(20);
    rec;
    wr(8'h3e, 16'h0800);
    cyc(2);
    wr(8'h1a, 16'h0102);
    trig(0);
    cyc(2);
    wr(8'h3e, 16'h0800);
    rd(8'h40, 16'h0001, 16'h003f);
    smp(16'h0aaa, 16'h0bbb, 0);
    cyc(10);
    wr(8'h1a, 16'h0103);
    trig(0);
    rd(8'h06, 16'h0000, 16'hffff);
    chk(RT_ACTIVE, 1);
    for (i = 0; i < 8; i++) smp(16'h1234, 16'h5678, 0);
    chk(RT_DATA, 16'h1234);
    rd(8'h08, 16'h1234, 16'hffff);
    for (i = 0; i < 8; i++) smp(16'h1234, 16'h5678, 0);
    chk(RT_DATA, 16'h5678);
    wr(8'h3e, 16'h0800);
    cyc(2);
    chk(RT_ACTIVE, 0);
    give_verdict;
  end
endmodule // tb
